// File: core/shutter_cmd_pkg.sv
/*
  Constants, types and command decoders for the shutter command interpreter.
  Assumes one 100 MHz clock domain and a byte link on the same clock.
*/
// Behaviour
// RL1 - Byte commands; collect all parameter bytes first
// RL2 - Classify byte as shutter or special command
// RL3 - Send completion byte 0x0d after each command
// RL4 - Byte 0xaa opens the shutter
// RL5 - Byte 0xac closes the shutter
// RL6 - Byte 0xdc selects fast motion mode
// RL7 - Byte 0xdd selects soft motion mode
// RL8 - Byte 0xde plus microsteps 1..144 sets attenuation
// RL9 - Prefix 0xfa 0xf0 plus 16-bit repeat count
// RL10 - Count above 65000 means unlimited repeats
// RL11 - Prefix 0xf1 arms autorun at power-up
// RL12 - Prefix 0xf2 starts autorun on trigger pulse
// RL13 - Prefix 0xf3 starts autorun at once
// RL14 - Byte 0xfb resets and reloads saved configuration
// RL15 - Byte 0xfd reports controller type
// RL16 - Completion byte withheld until command fully done
package shutter_cmd_pkg;

  // ==========================================================
  // Command and answer bytes
  localparam logic [7:0] CMD_OPEN = 8'haa;
  localparam logic [7:0] CMD_CLOSE = 8'hac;
  localparam logic [7:0] CMD_FAST = 8'hdc;
  localparam logic [7:0] CMD_SOFT = 8'hdd;
  localparam logic [7:0] CMD_ATTEN = 8'hde;
  localparam logic [7:0] CMD_PREFIX = 8'hfa;
  localparam logic [7:0] CMD_RELOAD = 8'hfb;
  localparam logic [7:0] CMD_QUERY = 8'hfd;
  localparam logic [7:0] SUB_COUNT = 8'hf0;
  localparam logic [7:0] SUB_POWER_UP = 8'hf1;
  localparam logic [7:0] SUB_TRIGGER = 8'hf2;
  localparam logic [7:0] SUB_NOW = 8'hf3;
  localparam logic [7:0] DONE_BYTE = 8'h0d;

  // ==========================================================
  // Limits and reset values
  localparam logic [7:0] STEPS_MIN = 8'h01;
  localparam logic [7:0] STEPS_MAX = 8'h90;
  localparam logic [15:0] COUNT_MAX = 16'hfde8;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] STEPS_RST = 8'h01;

  // Interpreter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PREFIX = 3'b001,
    ST_STEPS = 3'b010,
    ST_CNT_HI = 3'b011,
    ST_CNT_LO = 3'b100,
    ST_TYPE = 3'b101,
    ST_DONE = 3'b110
  } state_type;

  // Shutter motion modes
  typedef enum logic [1:0] {
    MODE_FAST = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_ATTEN = 2'b10
  } mode_type;

  // ==========================================================
  // Command decoders
  // True for a byte that is one of the shutter commands
  function automatic logic is_shutter_cmd(input logic [7:0] b);
    is_shutter_cmd = (b == CMD_OPEN) || (b == CMD_CLOSE) || (b == CMD_FAST) ||
                     (b == CMD_SOFT) || (b == CMD_ATTEN);
  endfunction

  // True for a single-byte or prefix special command
  function automatic logic is_special_cmd(input logic [7:0] b);
    is_special_cmd = (b == CMD_PREFIX) || (b == CMD_RELOAD) || (b == CMD_QUERY);
  endfunction

endpackage

// File: core/shutter_command_interpreter.sv
/*
  Byte command interpreter for a motorised shutter controller.
  Assumes received bytes arrive as one-cycle strobes on i_sys_clk, and that
  the host waits for the completion byte before sending the next command.
*/
`timescale 1ns/100ps
module shutter_command_interpreter
  import shutter_cmd_pkg::*;
#(
  parameter logic [7:0] CTRL_TYPE = 8'h5a  // Type answer; value is arbitrary
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_valid,
  input wire logic i_tx_ready,
  input wire logic i_trig,
  output logic [7:0] o_tx_byte,
  output logic o_tx_valid,
  output logic o_shutter_open,
  output logic [1:0] o_motion_mode,
  output logic [7:0] o_steps,
  output logic [15:0] o_repeat_count,
  output logic o_repeat_infinite,
  output logic o_autorun_power_up,
  output logic o_autorun_on_trig,
  output logic o_autorun_start,
  output logic o_reload_cfg
);

  // ==========================================================
  // State
  state_type st_r, st_nxt;  // Interpreter position
  logic [7:0] cnt_hi_r, cnt_hi_nxt;  // High byte of repeat count
  logic [7:0] tx_byte_r, tx_byte_nxt;  // Byte offered to host
  logic tx_valid_r, tx_valid_nxt;  // Offer pending
  logic open_r, open_nxt;  // Shutter commanded open
  mode_type mode_r, mode_nxt;  // Motion mode
  logic [7:0] steps_r, steps_nxt;  // Attenuation microsteps
  logic [15:0] count_r, count_nxt;  // Autorun repeat count
  logic inf_r, inf_nxt;  // Unlimited repeats
  logic pwr_r, pwr_nxt;  // Autorun at power-up
  logic trg_r, trg_nxt;  // Autorun armed on trigger
  logic start_r, start_nxt;  // Autorun start pulse
  logic reload_r, reload_nxt;  // Reload request pulse
  logic trig_s1_r, trig_s2_r, trig_s3_r;  // Trigger synchroniser and edge stage
  logic trig_rise;  // Synchronised rising edge
  logic [15:0] full_count;  // Assembled repeat count

  // Trigger edge, from the second synchroniser flop and the third, edge-stage flop
  assign trig_rise = trig_s2_r & ~trig_s3_r;
  assign full_count = {cnt_hi_r, i_rx_byte};

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    cnt_hi_nxt = cnt_hi_r;
    tx_byte_nxt = tx_byte_r;
    tx_valid_nxt = tx_valid_r;
    open_nxt = open_r;
    mode_nxt = mode_r;
    steps_nxt = steps_r;
    count_nxt = count_r;
    inf_nxt = inf_r;
    pwr_nxt = pwr_r;
    trg_nxt = trg_r;
    start_nxt = 1'b0;
    reload_nxt = 1'b0;
    if (trg_r && trig_rise) begin  // Armed trigger fires once, then disarms
      start_nxt = 1'b1;  // RL12
      trg_nxt = 1'b0;
    end
    case (st_r)
      ST_IDLE: begin
        if (i_rx_valid) begin
          if (is_shutter_cmd(i_rx_byte)) begin  // RL2
            st_nxt = ST_DONE;
            tx_valid_nxt = 1'b1;
            tx_byte_nxt = DONE_BYTE;
            case (i_rx_byte)
              CMD_OPEN: open_nxt = 1'b1;  // RL4
              CMD_CLOSE: open_nxt = 1'b0;  // RL5
              CMD_FAST: mode_nxt = MODE_FAST;  // RL6
              CMD_SOFT: mode_nxt = MODE_SOFT;  // RL7
              default: begin  // Attenuation waits for its step byte
                st_nxt = ST_STEPS;  // RL1
                tx_valid_nxt = 1'b0;
              end
            endcase
          end else if (is_special_cmd(i_rx_byte)) begin  // RL2
            case (i_rx_byte)
              CMD_PREFIX: st_nxt = ST_PREFIX;  // RL1
              CMD_RELOAD: begin  // Shutter, mode, steps and trigger arm fall back, store outside rewrites them
                reload_nxt = 1'b1;  // RL14
                open_nxt = 1'b0;
                mode_nxt = MODE_FAST;
                steps_nxt = STEPS_RST;
                trg_nxt = 1'b0;
                st_nxt = ST_DONE;
                tx_valid_nxt = 1'b1;
                tx_byte_nxt = DONE_BYTE;
              end
              default: begin
                st_nxt = ST_TYPE;  // RL15
                tx_valid_nxt = 1'b1;
                tx_byte_nxt = CTRL_TYPE;
              end
            endcase
          end  // Unknown bytes are dropped with no answer
        end
      end
      ST_PREFIX: begin
        if (i_rx_valid) begin
          st_nxt = ST_DONE;
          tx_valid_nxt = 1'b1;  // RL3
          tx_byte_nxt = DONE_BYTE;
          case (i_rx_byte)
            SUB_COUNT: begin
              st_nxt = ST_CNT_HI;  // RL9
              tx_valid_nxt = 1'b0;  // RL16
            end
            SUB_POWER_UP: pwr_nxt = 1'b1;  // RL11
            SUB_TRIGGER: trg_nxt = 1'b1;  // RL12
            SUB_NOW: start_nxt = 1'b1;  // RL13
            default: st_nxt = ST_DONE;  // Unknown prefix options still complete
          endcase
        end
      end
      ST_STEPS: begin  // Out-of-range counts leave the position untouched
        if (i_rx_valid) begin
          if (i_rx_byte >= STEPS_MIN && i_rx_byte <= STEPS_MAX) begin
            steps_nxt = i_rx_byte;  // RL8
            mode_nxt = MODE_ATTEN;
          end
          st_nxt = ST_DONE;
          tx_valid_nxt = 1'b1;  // RL16
          tx_byte_nxt = DONE_BYTE;
        end
      end
      ST_CNT_HI: begin
        if (i_rx_valid) begin
          cnt_hi_nxt = i_rx_byte;  // RL9
          st_nxt = ST_CNT_LO;
        end
      end
      ST_CNT_LO: begin
        if (i_rx_valid) begin
          count_nxt = full_count;  // RL9
          inf_nxt = (full_count > COUNT_MAX);  // RL10
          st_nxt = ST_DONE;
          tx_valid_nxt = 1'b1;  // RL16
          tx_byte_nxt = DONE_BYTE;
        end
      end
      ST_TYPE: begin  // Type byte is followed by the completion byte
        if (i_tx_ready) begin
          st_nxt = ST_DONE;
          tx_byte_nxt = DONE_BYTE;  // RL3
        end
      end
      ST_DONE: begin
        if (i_tx_ready) begin
          st_nxt = ST_IDLE;
          tx_valid_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        tx_valid_nxt = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      cnt_hi_r <= 8'h00;
      tx_byte_r <= DONE_BYTE;
      tx_valid_r <= 1'b0;
      open_r <= 1'b0;
      mode_r <= MODE_FAST;
      steps_r <= STEPS_RST;
      count_r <= COUNT_RST;
      inf_r <= 1'b0;
      pwr_r <= 1'b0;
      trg_r <= 1'b0;
      start_r <= 1'b0;
      reload_r <= 1'b0;
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_hi_r <= cnt_hi_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_valid_r <= tx_valid_nxt;
      open_r <= open_nxt;
      mode_r <= mode_nxt;
      steps_r <= steps_nxt;
      count_r <= count_nxt;
      inf_r <= inf_nxt;
      pwr_r <= pwr_nxt;
      trg_r <= trg_nxt;
      start_r <= start_nxt;
      reload_r <= reload_nxt;
      trig_s1_r <= i_trig;  // Two flops against metastability, a third for the edge
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end

  assign o_tx_byte = tx_byte_r;
  assign o_tx_valid = tx_valid_r;
  assign o_shutter_open = open_r;
  assign o_motion_mode = mode_r;
  assign o_steps = steps_r;
  assign o_repeat_count = count_r;
  assign o_repeat_infinite = inf_r;
  assign o_autorun_power_up = pwr_r;
  assign o_autorun_on_trig = trg_r;
  assign o_autorun_start = start_r;
  assign o_reload_cfg = reload_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  logic idle_rx;
  assign idle_rx = (st_r == ST_IDLE) && i_rx_valid;

  property p_open;
    idle_rx && i_rx_byte == CMD_OPEN |=> o_shutter_open && o_tx_valid && o_tx_byte == DONE_BYTE;
  endproperty
  a_open: assert property (p_open) else $error("open not applied"); // RL4

  property p_close;
    idle_rx && i_rx_byte == CMD_CLOSE |=> !o_shutter_open;
  endproperty
  a_close: assert property (p_close) else $error("close not applied"); // RL5

  property p_fast;
    idle_rx && i_rx_byte == CMD_FAST |=> o_motion_mode == MODE_FAST;
  endproperty
  a_fast: assert property (p_fast) else $error("fast mode not set"); // RL6

  property p_soft;
    idle_rx && i_rx_byte == CMD_SOFT |=> o_motion_mode == MODE_SOFT;
  endproperty
  a_soft: assert property (p_soft) else $error("soft mode not set"); // RL7

  property p_steps;
    st_r == ST_STEPS && i_rx_valid && i_rx_byte >= STEPS_MIN && i_rx_byte <= STEPS_MAX
      |=> o_steps == $past(i_rx_byte) && o_motion_mode == MODE_ATTEN;
  endproperty
  a_steps: assert property (p_steps) else $error("step count not applied"); // RL8

  property p_count;
    st_r == ST_CNT_LO && i_rx_valid |=> o_repeat_count == $past(full_count)
      && o_repeat_infinite == ($past(full_count) > COUNT_MAX);
  endproperty
  a_count: assert property (p_count) else $error("repeat count wrong"); // RL10

  property p_withhold;
    st_r == ST_PREFIX || st_r == ST_STEPS || st_r == ST_CNT_HI || st_r == ST_CNT_LO |-> !o_tx_valid;
  endproperty
  a_withhold: assert property (p_withhold) else $error("answer before command done"); // RL16

  property p_now;
    st_r == ST_PREFIX && i_rx_valid && i_rx_byte == SUB_NOW |=> o_autorun_start ##1 !o_autorun_start;
  endproperty
  a_now: assert property (p_now) else $error("autorun start not pulsed"); // RL13

  property p_reload;
    idle_rx && i_rx_byte == CMD_RELOAD |=> o_reload_cfg && !o_shutter_open;
  endproperty
  a_reload: assert property (p_reload) else $error("reload not requested"); // RL14

  property p_query;
    idle_rx && i_rx_byte == CMD_QUERY |=> o_tx_valid && o_tx_byte == CTRL_TYPE;
  endproperty
  a_query: assert property (p_query) else $error("type not reported"); // RL15

  property p_unknown;
    idle_rx && !is_shutter_cmd(i_rx_byte) && !is_special_cmd(i_rx_byte) |=> st_r == ST_IDLE && !o_tx_valid;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown byte acted on"); // RL2

  c_count: cover property (st_r == ST_CNT_LO && i_rx_valid);
  c_steps: cover property (st_r == ST_STEPS && i_rx_valid);
  c_query_done: cover property (st_r == ST_TYPE && i_tx_ready ##1 st_r == ST_DONE);
  c_trigger: cover property (o_autorun_on_trig && trig_rise);

endmodule

// File: test/host_link_model.sv
/*
  Host side of the byte link: sends whole commands and takes answer bytes.
  Assumes the interpreter offers one answer byte at a time with valid/ready.
*/
`timescale 1ns/100ps
module host_link_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_tx_ready
);
  // ==========================================================
  // State
  logic slow = 1'b0; // Set by the bench to stall answers
  logic [1:0] gap = 2'h0; // Stall phase, ready one cycle in four
  logic [7:0] got[$]; // Answer bytes taken so far
  int n_got = 0; // Answers taken; moved after the edge, so readers see no race
  logic rdy_nxt; // Ready that the interpreter samples at the coming rising edge

  // Idle link at time zero
  initial begin
    o_rx_byte = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b1;
  end

  // Whole command, bytes back to back, first byte from the top of c
  task automatic send(input logic [31:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge i_sys_clk);
      o_rx_byte = c[31-8*i -: 8];
      o_rx_valid = 1'b1;
    end
    @(negedge i_sys_clk);
    o_rx_byte = ~o_rx_byte; // Released line shows no stale value
    o_rx_valid = 1'b0;
  endtask

  // Ready for the coming rising edge is decided here, so a byte is noted
  // with the same ready value that the interpreter samples at that edge
  always @(negedge i_sys_clk) begin
    rdy_nxt = !slow || (gap == 2'h3);
    if (i_tx_valid && rdy_nxt) begin
      got.push_back(i_tx_byte);
      n_got <= n_got + 1;
    end
    gap <= gap + 2'h1;
    o_tx_ready <= rdy_nxt;
  end
endmodule

// File: test/shutter_command_interpreter_bench.sv
/*
  Self-checking bench for the shutter command interpreter.
  Assumes the host model above and the default type answer parameter.
*/
`timescale 1ns/100ps
module shutter_command_interpreter_bench;
  import shutter_cmd_pkg::*;
  // ==========================================================
  // Signals
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_trig = 1'b0;
  logic [7:0] rx_byte, tx_byte, steps;
  logic rx_valid, tx_ready, tx_valid, opn, inf, pwr, on_trig, start, reload;
  logic [1:0] mode;
  logic [15:0] cnt;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int starts = 0; // Autorun start pulses seen
  int reloads = 0; // Reload pulses seen
  typedef struct packed {
    logic [31:0] cmd;
    logic [2:0] n;
    logic opn;
    logic [1:0] mode;
    logic [7:0] steps;
    logic [15:0] cnt;
    logic inf;
  } row_type;
  row_type rows[10];

  always #5 i_sys_clk = ~i_sys_clk;

  shutter_command_interpreter dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_rx_byte(rx_byte), .i_rx_valid(rx_valid), .i_tx_ready(tx_ready), .i_trig(i_trig),
    .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .o_shutter_open(opn), .o_motion_mode(mode),
    .o_steps(steps), .o_repeat_count(cnt), .o_repeat_infinite(inf),
    .o_autorun_power_up(pwr), .o_autorun_on_trig(on_trig), .o_autorun_start(start),
    .o_reload_cfg(reload));
  host_link_model host (.i_sys_clk(i_sys_clk), .i_tx_byte(tx_byte), .i_tx_valid(tx_valid),
    .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_tx_ready(tx_ready));

  // Pulses are counted off the sampling edge, where they have settled
  always @(negedge i_sys_clk) begin
    starts += (start === 1'b1);
    reloads += (reload === 1'b1);
  end

  // ==========================================================
  // Checks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bounded wait for k more answer bytes, the last one the completion byte
  task automatic wait_ans(input int k);
    int t;
    t = host.n_got + k;
    for (int i = 0; i < 80 && host.n_got < t; i++) begin
      @(negedge i_sys_clk);
    end
    check("answer count", 16'(host.n_got), 16'(t));
    if (host.got.size() > 0) begin
      check("done byte", {8'h00, host.got[$]}, {8'h00, DONE_BYTE});
    end
    @(negedge i_sys_clk);
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the 144 cycles the run needs
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      give_verdict();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    rows[0] = '{32'haa000000, 3'd1, 1'b1, 2'b00, 8'h01, 16'h0000, 1'b0};
    rows[1] = '{32'hac000000, 3'd1, 1'b0, 2'b00, 8'h01, 16'h0000, 1'b0};
    rows[2] = '{32'hdd000000, 3'd1, 1'b0, 2'b01, 8'h01, 16'h0000, 1'b0};
    rows[3] = '{32'hde900000, 3'd2, 1'b0, 2'b10, 8'h90, 16'h0000, 1'b0};
    rows[4] = '{32'hde010000, 3'd2, 1'b0, 2'b10, 8'h01, 16'h0000, 1'b0};
    rows[5] = '{32'hdc000000, 3'd1, 1'b0, 2'b00, 8'h01, 16'h0000, 1'b0};
    rows[6] = '{32'hfaf0fde8, 3'd4, 1'b0, 2'b00, 8'h01, 16'hfde8, 1'b0};
    rows[7] = '{32'hfaf0fde9, 3'd4, 1'b0, 2'b00, 8'h01, 16'hfde9, 1'b1};
    rows[8] = '{32'hfaf0ffff, 3'd4, 1'b0, 2'b00, 8'h01, 16'hffff, 1'b1};
    rows[9] = '{32'hfaf00000, 3'd4, 1'b0, 2'b00, 8'h01, 16'h0000, 1'b0};
    repeat (10) @(negedge i_sys_clk);
    check("reset answer", {8'h00, tx_byte}, 16'h000d);
    check("reset steps", {8'h00, steps}, 16'h0001);
    i_rst_n = 1'b1;
    // Ordinary commands, one answer each
    foreach (rows[r]) begin
      host.send(rows[r].cmd, int'(rows[r].n));
      wait_ans(1);
      check("open", {15'h0, opn}, {15'h0, rows[r].opn});
      check("mode", {14'h0, mode}, {14'h0, rows[r].mode});
      check("steps", {8'h00, steps}, {8'h00, rows[r].steps});
      check("count", cnt, rows[r].cnt);
      check("infinite", {15'h0, inf}, {15'h0, rows[r].inf});
    end
    // Count held back until its last byte; stalled host reader
    host.slow = 1'b1;
    host.send(32'hfaf01200, 3);
    repeat (4) @(negedge i_sys_clk);
    check("early answer", {15'h0, tx_valid}, 16'h0000);
    host.send(32'h34000000, 1);
    wait_ans(1);
    check("count", cnt, 16'h1234);
    // Out of range step count is refused but answered
    host.send(32'hde910000, 2);
    wait_ans(1);
    check("steps kept", {8'h00, steps}, 16'h0001);
    // Query answers type then completion
    host.send(32'hfd000000, 1);
    wait_ans(2);
    check("type", {8'h00, host.got[$-1]}, 16'h005a);
    host.slow = 1'b0;
    // Unknown first byte gets no answer
    host.send(32'h55000000, 1);
    repeat (6) @(negedge i_sys_clk);
    check("no answer", {15'h0, tx_valid}, 16'h0000);
    host.send(32'hfa770000, 2);
    wait_ans(1);
    // Autorun: power up, at once, on trigger; count already set
    host.send(32'hfaf10000, 2);
    wait_ans(1);
    check("power up", {15'h0, pwr}, 16'h0001);
    host.send(32'hfaf30000, 2);
    wait_ans(1);
    check("start now", 16'(starts), 16'h0001);
    host.send(32'hfaf20000, 2);
    wait_ans(1);
    check("armed", {15'h0, on_trig}, 16'h0001);
    check("no early start", 16'(starts), 16'h0001);
    i_trig = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    check("trig start", 16'(starts), 16'h0002);
    check("disarmed", {15'h0, on_trig}, 16'h0000);
    // Reload from saved configuration
    host.send(32'haa000000, 1);
    wait_ans(1);
    host.send(32'hfb000000, 1);
    wait_ans(1);
    check("reload", 16'(reloads), 16'h0001);
    check("closed", {15'h0, opn}, 16'h0000);
    // Mid-run reset drops sticky flags and the count, then the link works again
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    check("reset power up", {15'h0, pwr}, 16'h0000);
    check("reset count", cnt, 16'h0000);
    check("reset valid", {15'h0, tx_valid}, 16'h0000);
    i_rst_n = 1'b1;
    host.send(32'haa000000, 1);
    wait_ans(1);
    check("open after reset", {15'h0, opn}, 16'h0001);
    give_verdict();
  end
endmodule
